// ===== rucs_pkg.sv
`default_nettype none
package rucs_pkg;
    localparam logic [11:0] OFF_CMD      = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    localparam logic [11:0] OFF_ERR0     = 12'h008;
    localparam logic [11:0] OFF_ERR1     = 12'h00c;
    localparam logic [11:0] OFF_CAP_LO   = 12'h010;
    localparam logic [11:0] OFF_CAP_HI   = 12'h014;
    localparam logic [11:0] OFF_ADR_LO   = 12'h018;
    localparam logic [11:0] OFF_ADR_HI   = 12'h01c;
    localparam logic [11:0] OFF_LEN_LO   = 12'h020;
    localparam logic [11:0] OFF_LEN_HI   = 12'h024;
    localparam logic [11:0] OFF_PATT     = 12'h028;
    localparam logic [11:0] OFF_CNT_LO   = 12'h02c;
    localparam logic [11:0] OFF_CNT_HI   = 12'h030;
    localparam logic [11:0] OFF_TIMEOUT  = 12'h034;
    localparam logic [11:0] OFF_INT_STAT = 12'h038;
    localparam logic [11:0] OFF_INT_MASK = 12'h03c;
    localparam logic [4:0]  SUB_PAGE     = 5'h08;
    localparam int          BIT_BUSY     = 0;
    localparam int          BIT_ERR      = 1;
    localparam int          BIT_VFAIL    = 2;
    localparam int          BIT_SHUT     = 3;
    localparam int          INT_DONE     = 0;
    localparam int          INT_ERR      = 1;
    localparam int          INT_VFAIL    = 2;
    localparam int          INT_W        = 3;
    localparam logic [2:0]  CODE_IDEN    = 3'h0;
    localparam logic [2:0]  CODE_SHUT    = 3'h1;
    localparam logic [2:0]  CODE_WRITE   = 3'h2;
    localparam logic [2:0]  CODE_READ    = 3'h3;
    localparam logic [2:0]  CODE_CUSTOM  = 3'h4;
    localparam logic [2:0]  CODE_FLUSH   = 3'h6;
    localparam logic [31:0] TIMEOUT_RST  = 32'h05f5_e100;
    localparam logic [31:0] PATT_RST     = 32'h0000_0000;
    localparam logic [2:0]  INT_MASK_RST = 3'h0;
    localparam int          CNT_W        = 57;

    typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_RUN, ST_FAULT, ST_DEAD} rucs_state_t;

    typedef struct packed {
        logic            init_done;
        logic            init_error;
        logic            op_done;
        logic            op_error;
        logic            verify_fail;
        logic            xfer_valid;
        logic [15:0]     xfer_bytes;
        logic            sector_mode;
        logic [31:0]     cap_lo;
        logic [30:0]     cap_hi;
        logic [1:0][31:0] err_type;
    } rucs_back_t;

    typedef struct packed {
        logic            op_start;
        logic [2:0]      op_code;
        logic [63:0]     start_addr;
        logic [63:0]     length;
        logic [31:0]     pattern;
        logic [31:0]     timeout;
    } rucs_req_t;
endpackage
`default_nettype wire

// ===== rucs_ram.sv
`timescale 1ns/1ps
`default_nettype none
module rucs_ram #(
    parameter int AW = 12,
    parameter int DW = 32
) (
    input  wire logic          hclk,
    input  wire logic          a_we,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic [DW-1:0] a_wdata,
    output logic      [DW-1:0] a_rdata,
    input  wire logic          b_we,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic [DW-1:0] b_wdata
);
    logic [DW-1:0] mem [2**AW];

    // backend port wins a same-address collision
    always_ff @(posedge hclk) begin
        if (a_we && !(b_we && b_addr == a_addr)) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
    end
endmodule
`default_nettype wire

// ===== rucs_timeout.sv
`timescale 1ns/1ps
`default_nettype none
module rucs_timeout (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        run,
    input  wire logic [31:0] limit,
    output logic             expired
);
    logic [31:0] cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt     <= 32'h0;
            expired <= 1'b0;
        end else if (!run || limit == 32'h0) begin
            cnt     <= 32'h0;
            expired <= 1'b0;
        end else begin
            cnt     <= cnt + 32'h1;
            expired <= (cnt == limit - 32'h1);
        end
    end

    chk_timer_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (limit == 32'h0) |=> !expired) else $error("timer fired while disabled");
endmodule
`default_nettype wire

// ===== rucs_top.sv
`timescale 1ns/1ps
`default_nettype none
module rucs_top #(
    parameter int          IDEN_AW     = 12,
    parameter int          CTM_AW      = 12,
    parameter logic [31:0] TIMEOUT_DEF = rucs_pkg::TIMEOUT_RST
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire rucs_pkg::rucs_back_t back,
    output rucs_pkg::rucs_req_t       req,
    input  wire logic                 iden_we,
    input  wire logic [IDEN_AW-1:0]   iden_addr,
    input  wire logic [31:0]          iden_wdata,
    input  wire logic                 ctm_we,
    input  wire logic [CTM_AW-1:0]    ctm_addr,
    input  wire logic [31:0]          ctm_wdata,
    input  wire logic [4:0]           sub_addr,
    output logic [31:0]               sub_data,
    output logic                      irq
);
    import rucs_pkg::*;

    logic              ap_valid;
    logic              ap_write;
    logic [16:0]       ap_addr;
    logic [1:0]        rd_cnt;
    rucs_state_t       state;
    logic [2:0]        run_code;
    logic              err_flag;
    logic              vfail_flag;
    logic [CNT_W-1:0]  byte_cnt;
    logic [1:0][31:0]  err_word;
    logic [INT_W-1:0]  int_stat;
    logic [INT_W-1:0]  int_mask;
    logic [31:0]       sub_mem [32];
    logic [31:0]       iden_rdata;
    logic [31:0]       ctm_rdata;
    logic [31:0]       next_rdata;
    logic              tmo_expired;
    logic              busy;
    logic              wr_now;
    logic              is_reg;
    logic              is_sub;
    logic              is_iden;
    logic              is_ctm;
    logic              cmd_wr;
    logic              code_ok;
    logic              accept;
    logic              fail_ev;
    logic              done_ev;
    logic              vf_ev;
    logic [INT_W-1:0]  events;
    logic [INT_W-1:0]  w1c;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    assign hresp     = 1'b0;
    assign hreadyout = (rd_cnt == 2'h0);
    assign wr_now    = ap_valid && ap_write;
    assign is_reg    = !ap_addr[16] && ap_addr[11:7] < SUB_PAGE;
    assign is_sub    = !ap_addr[16] && ap_addr[11:7] == SUB_PAGE;
    assign is_iden   = ap_addr[16] && !ap_addr[15] && ap_addr[14] == 1'b0;
    assign is_ctm    = ap_addr[16] && ap_addr[15] && ap_addr[14] == 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 17'h0;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr[16:0];
        end else begin
            ap_valid <= 1'b0;
        end
    end

    // reads wait two cycles so buffer data comes out of a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_cnt <= 2'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            rd_cnt <= 2'h1;
        end else if (rd_cnt == 2'h1) begin
            rd_cnt <= 2'h2;
        end else begin
            rd_cnt <= 2'h0;
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (is_iden) begin
            next_rdata = iden_rdata;
        end else if (is_ctm) begin
            next_rdata = ctm_rdata;
        end else if (is_sub) begin
            next_rdata = sub_mem[ap_addr[6:2]];
        end else if (is_reg) begin
            case (ap_addr[11:0])
                OFF_STATUS: begin
                    next_rdata[BIT_BUSY]  = busy;
                    next_rdata[BIT_ERR]   = err_flag;
                    next_rdata[BIT_VFAIL] = vfail_flag;
                    next_rdata[BIT_SHUT]  = (state == ST_DEAD);
                end
                OFF_CMD:      next_rdata = {29'h0, run_code};
                OFF_ERR0:     next_rdata = err_word[0];
                OFF_ERR1:     next_rdata = err_word[1];
                OFF_CAP_LO:   next_rdata = back.cap_lo;
                OFF_CAP_HI:   next_rdata = {back.sector_mode, back.cap_hi};
                OFF_ADR_LO:   next_rdata = req.start_addr[31:0];
                OFF_ADR_HI:   next_rdata = req.start_addr[63:32];
                OFF_LEN_LO:   next_rdata = req.length[31:0];
                OFF_LEN_HI:   next_rdata = req.length[63:32];
                OFF_PATT:     next_rdata = req.pattern;
                OFF_CNT_LO:   next_rdata = byte_cnt[31:0];
                OFF_CNT_HI:   next_rdata = {7'h0, byte_cnt[CNT_W-1:32]};
                OFF_TIMEOUT:  next_rdata = req.timeout;
                OFF_INT_STAT: next_rdata = {29'h0, int_stat};
                OFF_INT_MASK: next_rdata = {29'h0, int_mask};
                default:      next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (rd_cnt == 2'h2) begin
            hrdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-loaded parameters; req has this one writer, start pulse included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req.op_start   <= 1'b0;
            req.op_code    <= CODE_IDEN;
            req.start_addr <= 64'h0;
            req.length     <= 64'h0;
            req.pattern    <= PATT_RST;
            req.timeout    <= TIMEOUT_DEF;
            int_mask       <= INT_MASK_RST;
        end else begin
            req.op_start <= accept;
            if (accept) begin
                req.op_code <= hwdata[2:0];
            end
            if (wr_now && is_reg) begin
                case (ap_addr[11:0])
                    OFF_ADR_LO:   req.start_addr[31:0]  <= hwdata;
                    OFF_ADR_HI:   req.start_addr[63:32] <= hwdata;
                    OFF_LEN_LO:   req.length[31:0]      <= hwdata;
                    OFF_LEN_HI:   req.length[63:32]     <= hwdata;
                    OFF_PATT:     req.pattern           <= hwdata;
                    OFF_TIMEOUT:  req.timeout           <= hwdata;
                    OFF_INT_MASK: int_mask              <= hwdata[INT_W-1:0];
                    default:      ;
                endcase
            end
        end
    end

    // submission entries, 32 words per channel
    always_ff @(posedge hclk) begin
        if (wr_now && is_sub) begin
            sub_mem[ap_addr[6:2]] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_data <= 32'h0;
        end else begin
            sub_data <= sub_mem[sub_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffers and timer
    // identify data kept per channel
    rucs_ram #(.AW(IDEN_AW), .DW(32)) u_iden (
        .hclk    (hclk),
        .a_we    (1'b0),
        .a_addr  (ap_addr[IDEN_AW+1:2]),
        .a_wdata (32'h0),
        .a_rdata (iden_rdata),
        .b_we    (iden_we),
        .b_addr  (iden_addr),
        .b_wdata (iden_wdata)
    );

    // custom results, software may also write
    rucs_ram #(.AW(CTM_AW), .DW(32)) u_ctm (
        .hclk    (hclk),
        .a_we    (wr_now && is_ctm),
        .a_addr  (ap_addr[CTM_AW+1:2]),
        .a_wdata (hwdata),
        .a_rdata (ctm_rdata),
        .b_we    (ctm_we),
        .b_addr  (ctm_addr),
        .b_wdata (ctm_wdata)
    );

    rucs_timeout u_tmo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state == ST_RUN),
        .limit   (req.timeout),
        .expired (tmo_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // command sequencing
    assign cmd_wr  = wr_now && is_reg && ap_addr[11:0] == OFF_CMD;
    assign code_ok = hwdata[2:0] != 3'h5 && hwdata[2:0] != 3'h7;
    // only an idle controller takes a command
    assign accept  = cmd_wr && code_ok && state == ST_IDLE;
    assign fail_ev = (state == ST_RUN && (back.op_error || tmo_expired))
                     || (state == ST_INIT && back.init_error);
    assign done_ev = state == ST_RUN && back.op_done && !fail_ev;
    assign vf_ev   = state == ST_RUN && back.verify_fail;
    // fault keeps busy high; error bit tells software to stop
    assign busy    = state == ST_INIT || state == ST_RUN || state == ST_FAULT;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_INIT;
        end else begin
            case (state)
                ST_INIT: begin
                    if (back.init_error) begin
                        state <= ST_FAULT;
                    end else if (back.init_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (fail_ev) begin
                        state <= ST_FAULT;
                    end else if (back.op_done) begin
                        state <= (run_code == CODE_SHUT) ? ST_DEAD : ST_IDLE;
                    end
                end
                ST_FAULT: state <= ST_FAULT;
                ST_DEAD:  state <= ST_DEAD;
                default:  state <= ST_INIT;
            endcase
        end
    end

    // custom code passed as is; entry picks erase or log
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_code <= CODE_IDEN;
        end else if (accept) begin
            run_code <= hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_flag <= 1'b0;
            err_word <= '0;
        end else if (fail_ev) begin
            err_flag <= 1'b1;
            err_word <= back.err_type;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vfail_flag <= 1'b0;
        end else if (vf_ev) begin
            vfail_flag <= 1'b1;
        end else if (accept) begin
            vfail_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_cnt <= '0;
        end else if (accept && (hwdata[2:0] == CODE_WRITE || hwdata[2:0] == CODE_READ)) begin
            byte_cnt <= '0;
        end else if (state == ST_RUN && back.xfer_valid) begin
            byte_cnt <= byte_cnt + CNT_W'(back.xfer_bytes);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts; a new event beats a same-cycle clear
    assign events = {vf_ev, fail_ev, done_ev};
    assign w1c    = (wr_now && is_reg && ap_addr[11:0] == OFF_INT_STAT)
                    ? hwdata[INT_W-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat <= '0;
        end else begin
            int_stat <= (int_stat & ~w1c) | events;
        end
    end

    assign irq = |(int_stat & int_mask);

    ////////////////////////////////////////////////////////////////////////
    chk_busy_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        accept |=> busy && req.op_start && state == ST_RUN)
        else $error("accepted command did not raise busy");
    chk_init_busy: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == ST_INIT && !back.init_done && !back.init_error) |=> busy && state == ST_INIT)
        else $error("busy low during init");
    chk_ignore_busy: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_wr && busy) |=> !req.op_start && $stable(run_code))
        else $error("command taken while busy");
    chk_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev |=> !busy) else $error("busy stuck after completion");
    chk_error_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        fail_ev |=> err_flag && err_word == $past(back.err_type))
        else $error("failure not reported");
    chk_verify_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        (vf_ev && !fail_ev && !back.op_done) |=> vfail_flag && state == ST_RUN)
        else $error("verify failure aborted run");
    chk_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == ST_RUN && back.xfer_valid)
        |=> byte_cnt == $past(byte_cnt) + CNT_W'($past(back.xfer_bytes)))
        else $error("byte count wrong");
    chk_shut_dead: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_DEAD |=> state == ST_DEAD && !req.op_start && !busy)
        else $error("controller woke after shutdown");
    chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        events[INT_DONE] && int_mask[INT_DONE] |=> irq)
        else $error("done interrupt missing");
endmodule
`default_nettype wire

// ===== rucs_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rucs_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    rucs_back_t  back = '0;
    rucs_req_t   req;
    logic        iden_we = 1'b0;
    logic        ctm_we = 1'b0;
    logic [11:0] buf_addr = '0;
    logic [31:0] buf_wdata = '0;
    logic [4:0]  sub_addr = '0;
    logic [31:0] sub_data;
    logic        irq;
    logic [31:0] r;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;

    rucs_top i_rucs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .back(back), .req(req),
        .iden_we(iden_we), .iden_addr(buf_addr), .iden_wdata(buf_wdata),
        .ctm_we(ctm_we), .ctm_addr(buf_addr), .ctm_wdata(buf_wdata),
        .sub_addr(sub_addr), .sub_data(sub_data), .irq(irq)
    );

    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    // hready judged at the rising edge, before that edge's updates land
    task automatic wait_rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string what);
        rd(a, r);
        chk(r, exp, what);
    endtask
    // poll status until busy clears or an error shows
    task automatic poll();
        do rd(OFF_STATUS, r); while (r[0] && !r[1]);
    endtask
    task automatic done();
        back.op_done <= 1'b1;
        @(posedge hclk);
        back.op_done <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        back <= '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        @(posedge hclk);
        do_reset();
        rc(OFF_STATUS, 32'h1, "busy in init");
        chk({31'h0, hresp}, 32'h0, "okay response");
        back.init_done <= 1'b1;
        @(posedge hclk);
        rc(OFF_STATUS, 32'h0, "ready");
        rc(OFF_TIMEOUT, TIMEOUT_RST, "timeout default");
        wr(OFF_CMD, 32'h0);
        @(posedge hclk);
        chk({31'h0, req.op_start}, 32'h1, "start pulse");
        rc(OFF_STATUS, 32'h1, "identify busy");
        chk({31'h0, req.op_start}, 32'h0, "pulse ends");
        chk({29'h0, req.op_code}, 32'h0, "identify code");
        back.cap_hi <= 31'h0000_0002;
        back.cap_lo <= 32'h0012_3400;
        iden_we <= 1'b1;
        buf_addr <= 12'h001;
        buf_wdata <= 32'h1234_abcd;
        @(posedge hclk);
        iden_we <= 1'b0;
        done();
        rc(OFF_STATUS, 32'h0, "identify done");
        rc(32'h0001_0004, 32'h1234_abcd, "identify data");
        rc(OFF_CAP_LO, 32'h0012_3400, "capacity low");
        rc(OFF_CAP_HI, 32'h0000_0002, "capacity high");
        // mode bit set means 4 KB sectors, which the striping cannot take
        chk({31'h0, r[31]}, 32'h0, "large sectors");
        if (r[31]) print_verdict();
        wr(OFF_CMD, 32'h5);
        rc(OFF_STATUS, 32'h0, "bad code ignored");
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(OFF_INT_MASK, 32'h7);
        rc(OFF_INT_STAT, 32'h1, "done event");
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(OFF_INT_STAT, 32'h1);
        rc(OFF_INT_STAT, 32'h0, "event cleared");
        chk({31'h0, irq}, 32'h0, "irq off");
        wr(OFF_ADR_LO, 32'h0000_1000);
        wr(OFF_PATT, 32'h0000_0002);
        wr(OFF_CMD, 32'h2);
        wr(OFF_CMD, 32'h3);
        rc(OFF_CMD, 32'h2, "command while busy");
        chk(req.start_addr[31:0], 32'h0000_1000, "address copy");
        chk(req.pattern, 32'h2, "pattern copy");
        back.xfer_bytes <= 16'h0200;
        back.xfer_valid <= 1'b1;
        repeat (2) @(posedge hclk);
        back.xfer_valid <= 1'b0;
        @(posedge hclk);
        rc(OFF_CNT_LO, 32'h0000_0400, "byte count");
        rc(OFF_STATUS, 32'h1, "write busy");
        done();
        poll();
        wr(OFF_CMD, 32'h3);
        back.verify_fail <= 1'b1;
        @(posedge hclk);
        back.verify_fail <= 1'b0;
        @(posedge hclk);
        rc(OFF_STATUS, 32'h5, "read keeps running");
        rc(OFF_CNT_LO, 32'h0, "count cleared");
        done();
        rc(OFF_STATUS, 32'h4, "read done");
        wr(32'h0000_0404, 32'h0000_0002);
        sub_addr <= 5'h01;
        repeat (2) @(posedge hclk);
        chk(sub_data, 32'h2, "entry word");
        wr(OFF_TIMEOUT, 32'h0);
        wr(OFF_CMD, 32'h4);
        chk(req.timeout, 32'h0, "timer off");
        ctm_we <= 1'b1;
        buf_addr <= 12'h002;
        buf_wdata <= 32'h5a5a_0003;
        @(posedge hclk);
        ctm_we <= 1'b0;
        // long wait shows a zero limit never expires
        repeat (40) @(posedge hclk);
        done();
        rc(OFF_STATUS, 32'h0, "custom done");
        rc(32'h0001_8008, 32'h5a5a_0003, "custom data");
        wr(OFF_TIMEOUT, TIMEOUT_RST);
        wr(OFF_CMD, 32'h6);
        rc(OFF_STATUS, 32'h1, "flush busy");
        chk({29'h0, req.op_code}, 32'h6, "flush code");
        done();
        poll();
        wr(OFF_CMD, 32'h1);
        rc(OFF_STATUS, 32'h1, "shutdown busy");
        done();
        rc(OFF_STATUS, 32'h8, "shutdown done");
        wr(OFF_CMD, 32'h0);
        rc(OFF_STATUS, 32'h8, "stays inactive");
        do_reset();
        back.init_done <= 1'b1;
        back.err_type <= {32'h0000_0b02, 32'h0000_0a01};
        @(posedge hclk);
        wr(OFF_TIMEOUT, 32'd20);
        wr(OFF_CMD, 32'h2);
        poll();
        rc(OFF_STATUS, 32'h3, "timeout error");
        rc(OFF_ERR0, 32'h0000_0a01, "error word 0");
        rc(OFF_ERR1, 32'h0000_0b02, "error word 1");
        back.sector_mode <= 1'b1;
        rc(OFF_CAP_HI, 32'h8000_0000, "sector mode bit");
        print_verdict();
    end
endmodule
`default_nettype wire
